// file: css_command_select.sv
// Operation
// - Display format: decimal places in bits 0-3, unit code in bits 4-15.
// - User scale maximum zero disables scaling, nonzero enables it.
// - Scale maximum is unsigned; decimal point shifts by zero to three places.
// - Scale maximum maps to maximum frequency; value proportional to frequency.
// - User scaled value is read-only signed, shown only while maximum nonzero.
// - Scaled value valid only with remote frequency from keypad or serial.
// - Policy codes: HAND_OFF_AUTO, stop on switch, remote, local, follow selection.
// - Local/remote policy resets to code 4.
// - Policy 0 ignores the local/remote selector terminal.
// - Nonzero policy disables hand/auto keys; selector terminal then rules.
// - Local frequency source codes 0,1,2,3,4,7,9 select the command.
// - Power-up always enters remote mode.
// - Configured selector terminal beats every other local/remote request, except under policy 0, where hand/auto keys rule.
// - Local source 4 takes pulse input frequency without direction.
// - Local source 9 forces PID selector 1, remote source 9; locks.
// - Local source 9 accepts only PID frequency in both modes.
// - Local run source: 0 keypad, 1 terminals, 2 serial.
// - HAND_OFF_AUTO with both hand/auto terminals off blocks run and jog.
// - HAND_OFF_AUTO acts only with terminals 41, 42, 56 or keypad attached.
// - Stop-key enable field acts only while remote run not keypad.
// - Remote run source keypad means stop key always acts.
// - Random carrier modes 1-3 randomise carrier; 0 disables it.
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module css_command_select (
  // Clock and reset
  input  wire  logic                       core_clk,
  input  wire  logic                       rst,
  // Avalon-MM slave
  input  wire  logic [css_pkg::ADDR_W-1:0] avs_address,
  input  wire  logic                       avs_read,
  input  wire  logic                       avs_write,
  input  wire  logic [31:0]                avs_writedata,
  output logic [31:0]                      avs_readdata,
  output logic                             avs_waitrequest,
  // Keypad and terminal pins
  input  wire  logic                       hand_key,
  input  wire  logic                       auto_key,
  input  wire  logic                       stop_key,
  input  wire  logic                       term_hand_fn41,
  input  wire  logic                       term_auto_fn42,
  input  wire  logic                       term_remote_fn56,
  input  wire  logic                       keypad_attached,
  // Drive core
  input  wire  logic [15:0]                present_freq,
  output css_pkg::css_sel_type             cmd_sel,
  output css_pkg::css_disp_type            disp,
  output logic                             stop_cmd,
  output logic                             switch_stop
);

  logic [css_pkg::IDX_W-1:0] idx;
  logic [15:0] wdata;
  logic        ack_r;
  logic        wr_en;
  logic [31:0] rdata_r;
  logic [15:0] remote_freq_r, remote_run_r, disp_fmt_r, uscale_max_r;
  logic [15:0] uscaled_r, policy_r, local_freq_r, local_run_r;
  logic [15:0] stop_en_r, rand_carrier_r, term_cfg_r, pid_sel_r;
  logic [15:0] max_freq_r;

  assign idx   = avs_address[css_pkg::ADDR_W-1:2];
  assign wdata = avs_writedata[15:0];

  // One wait state: the answer is prepared in the first cycle.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_en           = avs_write & ack_r;
  assign avs_readdata    = rdata_r;

  function automatic logic [15:0] reg_read(
    input logic [css_pkg::IDX_W-1:0] a,
    input logic [15:0]               status);
    case (a)
      css_pkg::IDX_REMOTE_FREQ:  reg_read = remote_freq_r;
      css_pkg::IDX_REMOTE_RUN:   reg_read = remote_run_r;
      css_pkg::IDX_DISP_FORMAT:  reg_read = disp_fmt_r;
      css_pkg::IDX_USCALE_MAX:   reg_read = uscale_max_r;
      css_pkg::IDX_USCALED_VAL:  reg_read = uscaled_r;
      css_pkg::IDX_LR_POLICY:    reg_read = policy_r;
      css_pkg::IDX_LOCAL_FREQ:   reg_read = local_freq_r;
      css_pkg::IDX_LOCAL_RUN:    reg_read = local_run_r;
      css_pkg::IDX_STOP_ENABLE:  reg_read = stop_en_r;
      css_pkg::IDX_RAND_CARRIER: reg_read = rand_carrier_r;
      css_pkg::IDX_TERM_CONFIG:  reg_read = term_cfg_r;
      css_pkg::IDX_STATUS:       reg_read = status;
      css_pkg::IDX_PID_TARGET:   reg_read = pid_sel_r;
      css_pkg::IDX_MAX_FREQ:     reg_read = max_freq_r;
      default:                   reg_read = css_pkg::RST_ZERO;
    endcase
  endfunction

  function automatic logic hit(input logic [css_pkg::IDX_W-1:0] a);
    hit = wr_en && (idx == a);
  endfunction

  logic [15:0] status;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
      if (avs_read & ~ack_r) begin
        rdata_r <= {16'h0000, reg_read(idx, status)};
      end
    end
  end

  // Plain storage registers.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      remote_run_r   <= css_pkg::RST_ZERO;
      disp_fmt_r     <= css_pkg::RST_ZERO;
      uscale_max_r   <= css_pkg::RST_ZERO;
      policy_r       <= css_pkg::RST_LR_POLICY;
      local_run_r    <= css_pkg::RST_ZERO;
      stop_en_r      <= css_pkg::RST_ZERO;
      rand_carrier_r <= css_pkg::RST_ZERO;
      term_cfg_r     <= css_pkg::RST_ZERO;
      max_freq_r     <= css_pkg::RST_MAX_FREQ;
    end else begin
      if (hit(css_pkg::IDX_REMOTE_RUN))   remote_run_r   <= wdata;
      if (hit(css_pkg::IDX_DISP_FORMAT))  disp_fmt_r     <= wdata;
      if (hit(css_pkg::IDX_USCALE_MAX))   uscale_max_r   <= wdata;
      if (hit(css_pkg::IDX_LR_POLICY))    policy_r       <= wdata;
      if (hit(css_pkg::IDX_LOCAL_RUN))    local_run_r    <= wdata;
      if (hit(css_pkg::IDX_STOP_ENABLE))  stop_en_r      <= wdata;
      if (hit(css_pkg::IDX_RAND_CARRIER)) rand_carrier_r <= wdata;
      if (hit(css_pkg::IDX_TERM_CONFIG))  term_cfg_r     <= wdata;
      if (hit(css_pkg::IDX_MAX_FREQ))     max_freq_r     <= wdata;
    end
  end

  // PID lock: selecting PID locally pins the PID selector and remote source.
  logic pid_locked;
  logic lf_wr_ok;
  assign pid_locked = (pid_sel_r == css_pkg::PID_SEL_LOCK);
  assign lf_wr_ok   = !(pid_locked &&
                        local_freq_r[3:0] == css_pkg::CSS_FSRC_PID &&
                        wdata[3:0] != css_pkg::CSS_FSRC_PID);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      local_freq_r  <= css_pkg::RST_ZERO;
      remote_freq_r <= css_pkg::RST_ZERO;
      pid_sel_r     <= css_pkg::RST_ZERO;
    end else begin
      if (hit(css_pkg::IDX_LOCAL_FREQ) && lf_wr_ok) begin
        local_freq_r <= wdata;
      end
      if (hit(css_pkg::IDX_LOCAL_FREQ) &&
          wdata[3:0] == css_pkg::CSS_FSRC_PID) begin
        pid_sel_r     <= css_pkg::PID_SEL_LOCK;
        remote_freq_r <= {12'h000, css_pkg::CSS_FSRC_PID};
      end else begin
        if (hit(css_pkg::IDX_PID_TARGET))  pid_sel_r     <= wdata;
        if (hit(css_pkg::IDX_REMOTE_FREQ)) remote_freq_r <= wdata;
      end
    end
  end

  // Pins pass four flip-flops; a change counts once stages two and three agree.
  logic [css_pkg::PIN_N-1:0] pin_raw, pin_s1, pin_s2, pin_s3, pin_q;
  assign pin_raw = {term_remote_fn56, term_auto_fn42, term_hand_fn41,
                    stop_key, auto_key, hand_key};

  genvar g;
  generate
    for (g = 0; g < css_pkg::PIN_N; g++) begin : g_sync
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          pin_s1[g] <= 1'b0;
          pin_s2[g] <= 1'b0;
          pin_s3[g] <= 1'b0;
          pin_q[g]  <= 1'b0;
        end else begin
          pin_s1[g] <= pin_raw[g];
          pin_s2[g] <= pin_s1[g];
          pin_s3[g] <= pin_s2[g];
          if (pin_s2[g] == pin_s3[g]) pin_q[g] <= pin_s3[g];
        end
      end
    end
  endgenerate

  logic keypad_q, kp_s1, kp_s2, kp_s3;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      kp_s1    <= 1'b0;
      kp_s2    <= 1'b0;
      kp_s3    <= 1'b0;
      keypad_q <= 1'b0;
    end else begin
      kp_s1 <= keypad_attached;
      kp_s2 <= kp_s1;
      kp_s3 <= kp_s2;
      if (kp_s2 == kp_s3) keypad_q <= kp_s3;
    end
  end

  // Local/remote mode selection.
  logic hoa_policy, sel_term_cfg, hoa_active, local_r, local_nxt;
  assign hoa_policy   = (policy_r == 16'h0000);
  assign sel_term_cfg = term_cfg_r[css_pkg::TCFG_FN56];
  assign hoa_active   = term_cfg_r[css_pkg::TCFG_FN41] |
                        term_cfg_r[css_pkg::TCFG_FN42] |
                        sel_term_cfg | keypad_q;

  always_comb begin
    local_nxt = local_r;
    if (!hoa_policy) begin
      if (sel_term_cfg) local_nxt = pin_q[css_pkg::PIN_FN56];
    end else if (hoa_active) begin
      // Selector terminal ignored under plain HAND_OFF_AUTO.
      if (pin_q[css_pkg::PIN_HAND])      local_nxt = 1'b1;
      else if (pin_q[css_pkg::PIN_AUTO]) local_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      local_r     <= 1'b0;
      switch_stop <= 1'b0;
    end else begin
      local_r     <= local_nxt;
      switch_stop <= (policy_r[2:0] == css_pkg::CSS_POL_STOP) &&
                     (local_nxt != local_r);
    end
  end

  // Effective command sources.
  logic use_local;
  always_comb begin
    case (policy_r[2:0])
      css_pkg::CSS_POL_REMOTE: use_local = 1'b0;
      css_pkg::CSS_POL_LOCAL:  use_local = 1'b1;
      default:                 use_local = local_r;
    endcase
  end

  logic pid_only;
  logic [3:0] fsrc;
  logic [1:0] rsrc;
  logic hoa_block;
  assign pid_only  = (local_freq_r[3:0] == css_pkg::CSS_FSRC_PID);
  assign fsrc      = pid_only ? css_pkg::CSS_FSRC_PID :
                     use_local ? local_freq_r[3:0] :
                     remote_freq_r[3:0];
  assign rsrc      = use_local ? local_run_r[1:0] : remote_run_r[1:0];
  assign hoa_block = hoa_policy && hoa_active &&
                     !pin_q[css_pkg::PIN_FN41] &&
                     !pin_q[css_pkg::PIN_FN42];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmd_sel <= '0;
    end else begin
      cmd_sel.local_mode   <= local_r;
      cmd_sel.freq_src     <= css_pkg::css_fsrc_type'(fsrc);
      cmd_sel.run_src      <= css_pkg::css_rsrc_type'(rsrc);
      cmd_sel.run_enable   <= !hoa_block;
      cmd_sel.jog_valid    <= !hoa_block;
      cmd_sel.pulse_no_dir <= (fsrc == css_pkg::CSS_FSRC_PULSE);
      cmd_sel.pid_only     <= pid_only;
    end
  end

  // Stop key gating.
  logic stop_key_live;
  assign stop_key_live = (remote_run_r[1:0] == css_pkg::CSS_RSRC_KEYPAD) ||
                         stop_en_r[0];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) stop_cmd <= 1'b0;
    else     stop_cmd <= pin_q[css_pkg::PIN_STOP] && stop_key_live;
  end

  // User value = present_freq * scale_max / max_freq, by serial division.
  css_pkg::css_div_state_type div_st;
  logic [31:0] num_r, quo_r;
  logic [16:0] rem_r;
  logic [5:0]  cnt_r;
  logic [16:0] rem_sh;
  assign rem_sh = {rem_r[15:0], num_r[31]};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_st    <= css_pkg::CSS_DIV_IDLE;
      num_r     <= 32'h0000_0000;
      quo_r     <= 32'h0000_0000;
      rem_r     <= 17'h0_0000;
      cnt_r     <= 6'h00;
      uscaled_r <= css_pkg::RST_ZERO;
    end else begin
      case (div_st)
        css_pkg::CSS_DIV_IDLE: begin
          num_r  <= present_freq * uscale_max_r;
          quo_r  <= 32'h0000_0000;
          rem_r  <= 17'h0_0000;
          cnt_r  <= 6'h00;
          div_st <= css_pkg::CSS_DIV_RUN;
        end
        css_pkg::CSS_DIV_RUN: begin
          if (rem_sh >= {1'b0, max_freq_r}) begin
            rem_r <= rem_sh - {1'b0, max_freq_r};
            quo_r <= {quo_r[30:0], 1'b1};
          end else begin
            rem_r <= rem_sh;
            quo_r <= {quo_r[30:0], 1'b0};
          end
          num_r <= {num_r[30:0], 1'b0};
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == 6'(css_pkg::DIV_STEPS - 1)) begin
            div_st <= css_pkg::CSS_DIV_IDLE;
          end
        end
        default: div_st <= css_pkg::CSS_DIV_IDLE;
      endcase
      if (uscale_max_r == 16'h0000 || max_freq_r == 16'h0000) begin
        uscaled_r <= css_pkg::RST_ZERO;
      end else if (div_st == css_pkg::CSS_DIV_RUN &&
                   cnt_r == 6'(css_pkg::DIV_STEPS - 1)) begin
        uscaled_r <= (rem_sh >= {1'b0, max_freq_r}) ?
                     {quo_r[14:0], 1'b1} : {quo_r[14:0], 1'b0};
      end
    end
  end

  // Writes to the scaled value index have no decode above.

  logic [3:0] dec_field;
  assign dec_field = disp_fmt_r[css_pkg::DISP_DEC_LSB +: css_pkg::DISP_DEC_W];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      disp <= '0;
    end else begin
      disp.user_value <= uscaled_r;
      disp.user_valid <= (uscale_max_r != 16'h0000) &&
                         (remote_freq_r[3:0] == css_pkg::CSS_FSRC_KEYPAD ||
                          remote_freq_r[3:0] == css_pkg::CSS_FSRC_SERIAL);
      disp.decimals   <= (dec_field > css_pkg::DISP_DEC_MAX) ?
                         css_pkg::DISP_DEC_MAX[1:0] : dec_field[1:0];
      disp.unit       <= disp_fmt_r[css_pkg::DISP_UNIT_LSB +:
                                    css_pkg::DISP_UNIT_W];
      disp.carrier_random <= (rand_carrier_r[15:2] == 14'h0000) &&
                             (rand_carrier_r[1:0] != 2'h0);
      disp.carrier_mode   <= rand_carrier_r[1:0];
    end
  end

  assign status = {10'h000, pid_locked, hoa_active, keypad_q, stop_key_live,
                   use_local, local_r};

  // Checks.
  property p_policy_reset;
    @(posedge core_clk) $fell(rst) |-> policy_r == css_pkg::RST_LR_POLICY;
  endproperty
  a_policy_reset: assert property (p_policy_reset)
    else $error("policy not 4 after reset");

  property p_remote_after_reset;
    @(posedge core_clk) $fell(rst) |-> !local_r;
  endproperty
  a_remote_after_reset: assert property (p_remote_after_reset)
    else $error("not remote after reset");

  property p_zero_scale;
    @(posedge core_clk) disable iff (rst)
      uscale_max_r == 16'h0000 |=> uscaled_r == 16'h0000;
  endproperty
  a_zero_scale: assert property (p_zero_scale)
    else $error("scaled value nonzero with scaling off");

  property p_pid_force;
    @(posedge core_clk) disable iff (rst)
      wr_en && idx == css_pkg::IDX_LOCAL_FREQ &&
      wdata[3:0] == css_pkg::CSS_FSRC_PID
      |=> pid_locked && remote_freq_r[3:0] == css_pkg::CSS_FSRC_PID;
  endproperty
  a_pid_force: assert property (p_pid_force)
    else $error("PID lock not applied");

  property p_pid_only;
    @(posedge core_clk) disable iff (rst)
      pid_only |=> cmd_sel.freq_src == css_pkg::CSS_FSRC_PID;
  endproperty
  a_pid_only: assert property (p_pid_only)
    else $error("non-PID frequency while PID only");

  property p_hoa_block;
    @(posedge core_clk) disable iff (rst)
      hoa_block |=> !cmd_sel.run_enable && !cmd_sel.jog_valid;
  endproperty
  a_hoa_block: assert property (p_hoa_block)
    else $error("run allowed with hand/auto terminals off");

  property p_keypad_stop;
    @(posedge core_clk) disable iff (rst)
      remote_run_r[1:0] == css_pkg::CSS_RSRC_KEYPAD && pin_q[css_pkg::PIN_STOP]
      |=> stop_cmd;
  endproperty
  a_keypad_stop: assert property (p_keypad_stop)
    else $error("stop key blocked with keypad run source");

  property p_hoa_ignores_term;
    @(posedge core_clk) disable iff (rst)
      hoa_policy && !pin_q[css_pkg::PIN_HAND] && !pin_q[css_pkg::PIN_AUTO]
      |=> $stable(local_r);
  endproperty
  a_hoa_ignores_term: assert property (p_hoa_ignores_term)
    else $error("mode changed without hand/auto key under HAND_OFF_AUTO");

  property p_wait_one;
    @(posedge core_clk) disable iff (rst)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("bus answer later than one wait state");

  c_switch_stop: cover property (@(posedge core_clk) switch_stop);
  c_local_mode:  cover property (@(posedge core_clk) local_r);
  c_scaled:      cover property (@(posedge core_clk) uscaled_r != 16'h0000);

endmodule

`default_nettype wire

// file: css_pkg.sv
package css_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W  = 10;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [IDX_W-1:0] IDX_REMOTE_FREQ   = 10'h014;
  localparam logic [IDX_W-1:0] IDX_REMOTE_RUN    = 10'h015;
  localparam logic [IDX_W-1:0] IDX_DISP_FORMAT   = 10'h019;
  localparam logic [IDX_W-1:0] IDX_USCALE_MAX    = 10'h01A;
  localparam logic [IDX_W-1:0] IDX_USCALED_VAL   = 10'h01B;
  localparam logic [IDX_W-1:0] IDX_LR_POLICY     = 10'h01D;
  localparam logic [IDX_W-1:0] IDX_LOCAL_FREQ    = 10'h01E;
  localparam logic [IDX_W-1:0] IDX_LOCAL_RUN     = 10'h01F;
  localparam logic [IDX_W-1:0] IDX_STOP_ENABLE   = 10'h020;
  localparam logic [IDX_W-1:0] IDX_RAND_CARRIER  = 10'h021;
  localparam logic [IDX_W-1:0] IDX_TERM_CONFIG   = 10'h03E;
  localparam logic [IDX_W-1:0] IDX_STATUS        = 10'h03F;
  localparam logic [IDX_W-1:0] IDX_PID_TARGET    = 10'h0C1;
  localparam logic [IDX_W-1:0] IDX_MAX_FREQ      = 10'h100;

  // Reset values.
  localparam logic [DATA_W-1:0] RST_LR_POLICY = 16'h0004;
  localparam logic [DATA_W-1:0] RST_ZERO      = 16'h0000;
  localparam logic [DATA_W-1:0] RST_MAX_FREQ  = 16'h1770;

  // Display format field positions.
  localparam int unsigned DISP_DEC_LSB  = 0;
  localparam int unsigned DISP_DEC_W    = 4;
  localparam int unsigned DISP_UNIT_LSB = 4;
  localparam int unsigned DISP_UNIT_W   = 12;
  localparam logic [3:0]  DISP_DEC_MAX  = 4'h3;

  // Terminal configuration bits.
  localparam int unsigned TCFG_FN41 = 0;
  localparam int unsigned TCFG_FN42 = 1;
  localparam int unsigned TCFG_FN56 = 2;

  // Synchronised pin positions.
  localparam int unsigned PIN_HAND = 0;
  localparam int unsigned PIN_AUTO = 1;
  localparam int unsigned PIN_STOP = 2;
  localparam int unsigned PIN_FN41 = 3;
  localparam int unsigned PIN_FN42 = 4;
  localparam int unsigned PIN_FN56 = 5;
  localparam int unsigned PIN_N    = 6;

  localparam int unsigned DIV_STEPS = 32;

  typedef enum logic [2:0] {
    CSS_POL_HOA    = 3'h0,
    CSS_POL_STOP   = 3'h1,
    CSS_POL_REMOTE = 3'h2,
    CSS_POL_LOCAL  = 3'h3,
    CSS_POL_FOLLOW = 3'h4
  } css_policy_type;

  typedef enum logic [3:0] {
    CSS_FSRC_KEYPAD = 4'h0,
    CSS_FSRC_SERIAL = 4'h1,
    CSS_FSRC_ANALOG = 4'h2,
    CSS_FSRC_UPDOWN = 4'h3,
    CSS_FSRC_PULSE  = 4'h4,
    CSS_FSRC_POT    = 4'h7,
    CSS_FSRC_PID    = 4'h9
  } css_fsrc_type;

  typedef enum logic [1:0] {
    CSS_RSRC_KEYPAD = 2'h0,
    CSS_RSRC_TERM   = 2'h1,
    CSS_RSRC_SERIAL = 2'h2
  } css_rsrc_type;

  localparam logic [DATA_W-1:0] PID_SEL_LOCK = 16'h0001;

  typedef enum logic [1:0] {
    CSS_DIV_IDLE = 2'b01,
    CSS_DIV_RUN  = 2'b10
  } css_div_state_type;

  // Command selection presented to the drive core.
  typedef struct packed {
    logic         local_mode;
    css_fsrc_type freq_src;
    css_rsrc_type run_src;
    logic         run_enable;
    logic         jog_valid;
    logic         pulse_no_dir;
    logic         pid_only;
  } css_sel_type;

  // Display and carrier settings presented to the drive core.
  typedef struct packed {
    logic [DATA_W-1:0] user_value;
    logic              user_valid;
    logic [1:0]        decimals;
    logic [11:0]       unit;
    logic              carrier_random;
    logic [1:0]        carrier_mode;
  } css_disp_type;

endpackage

// file: css_panel_model.sv
`timescale 1ns/1ps
`default_nettype none

module css_panel_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Requested levels: hand, auto, stop, fn41, fn42, fn56, keypad
  input  wire logic [6:0] req,
  // Key and terminal pins toward the block
  output logic      [6:0] pins
);
  // Keys and terminals are held levels that move only just after an edge.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pins <= 7'h00;
    end else begin
      pins <= req;
    end
  end
endmodule

`default_nettype wire

// file: test_command_source_select.sv
`timescale 1ns/1ps
`default_nettype none

module test_command_source_select;
  typedef struct {
    logic [9:0]  idx;
    logic [15:0] rv;
    logic [15:0] wv;
    logic [15:0] ev;
  } row_type;
  logic                  core_clk = 1'b0;
  logic                  rst = 1'b1;
  logic [11:0]           avs_address = 12'h000;
  logic                  avs_read = 1'b0;
  logic                  avs_write = 1'b0;
  logic [31:0]           avs_writedata = 32'h0;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  logic [6:0]            req = 7'h00;
  logic [6:0]            pins;
  logic [15:0]           present_freq = 16'h0000;
  css_pkg::css_sel_type  cmd_sel;
  css_pkg::css_disp_type disp;
  logic                  stop_cmd;
  logic                  switch_stop;
  int                    sw_cnt = 0;
  logic [15:0]           q;
  int                    failures = 0;
  int                    tests_run = 0;
  row_type               rows [7];

  always #20 core_clk = ~core_clk;

  // Counts the one-cycle stop pulses raised on a mode change.
  always @(posedge core_clk) begin
    if (switch_stop === 1'b1) sw_cnt <= sw_cnt + 1;
  end

  css_panel_model u_css_panel_model (.core_clk(core_clk), .rst(rst),
    .req(req), .pins(pins));

  css_command_select u_css_command_select (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .hand_key(pins[0]),
    .auto_key(pins[1]), .stop_key(pins[2]), .term_hand_fn41(pins[3]),
    .term_auto_fn42(pins[4]), .term_remote_fn56(pins[5]),
    .keypad_attached(pins[6]), .present_freq(present_freq),
    .cmd_sel(cmd_sel), .disp(disp), .stop_cmd(stop_cmd),
    .switch_stop(switch_stop));

  task automatic print_verdict();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // The request stands until the rising edge at which waitrequest is low.
  task automatic bus(input logic wr, input logic [9:0] idx,
                     input logic [15:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {16'h0000, d};
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      $display("MISMATCH t=%0t bus answer timed out", $time);
      print_verdict();
    end
    q = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic rd_chk(input logic [9:0] idx, input logic [15:0] exp);
    bus(1'b0, idx, 16'h0000);
    chk(q, exp);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic setp(input logic [6:0] v);
    @(posedge core_clk);
    req <= v;
  endtask

  initial begin
    rows[0] = '{css_pkg::IDX_USCALE_MAX, 16'h0, 16'h03E8, 16'h03E8};
    rows[1] = '{css_pkg::IDX_USCALED_VAL, 16'h0, 16'h1234, 16'h0};
    rows[2] = '{css_pkg::IDX_LR_POLICY, 16'h4, 16'h0003, 16'h3};
    rows[3] = '{css_pkg::IDX_LOCAL_RUN, 16'h0, 16'h0002, 16'h2};
    rows[4] = '{css_pkg::IDX_STOP_ENABLE, 16'h0, 16'h0001, 16'h1};
    rows[5] = '{css_pkg::IDX_RAND_CARRIER, 16'h0, 16'h0002, 16'h2};
    rows[6] = '{10'h3FF, 16'h0, 16'hFFFF, 16'h0};
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    wt(1);
    chk(16'(cmd_sel.local_mode), 16'h0000);
    foreach (rows[i]) begin
      rd_chk(rows[i].idx, rows[i].rv);
      bus(1'b1, rows[i].idx, rows[i].wv);
      rd_chk(rows[i].idx, rows[i].ev);
    end
    bus(1'b1, css_pkg::IDX_DISP_FORMAT, 16'h01A2);
    wt(2);
    chk(16'(disp.decimals), 16'h0002);
    chk(16'(disp.unit), 16'h001A);
    @(posedge core_clk);
    present_freq <= 16'h0BB8;
    wt(70);
    chk(disp.user_value, 16'h01F4);
    chk(16'(disp.user_valid), 16'h0001);
    rd_chk(css_pkg::IDX_USCALED_VAL, 16'h01F4);
    bus(1'b1, css_pkg::IDX_USCALE_MAX, 16'h0000);
    wt(2);
    chk(16'(disp.user_valid), 16'h0000);
    chk(disp.user_value, 16'h0000);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, css_pkg::IDX_RAND_CARRIER, 16'(m));
      wt(2);
      chk(16'(disp.carrier_random), 16'(m != 0));
      chk(16'(disp.carrier_mode), 16'(m));
    end
    bus(1'b1, css_pkg::IDX_STOP_ENABLE, 16'h0000);
    setp(7'h04);
    wt(8);
    chk(16'(stop_cmd), 16'h0001);
    bus(1'b1, css_pkg::IDX_REMOTE_RUN, 16'h0002);
    wt(2);
    chk(16'(stop_cmd), 16'h0000);
    bus(1'b1, css_pkg::IDX_STOP_ENABLE, 16'h0001);
    wt(2);
    chk(16'(stop_cmd), 16'h0001);
    bus(1'b1, css_pkg::IDX_TERM_CONFIG, 16'h0004);
    setp(7'h22);
    wt(8);
    chk(16'(cmd_sel.local_mode), 16'h0001);
    bus(1'b1, css_pkg::IDX_LR_POLICY, 16'h0000);
    wt(8);
    chk(16'(cmd_sel.local_mode), 16'h0000);
    chk(16'(cmd_sel.run_enable), 16'h0000);
    chk(16'(cmd_sel.jog_valid), 16'h0000);
    setp(7'h00);
    bus(1'b1, css_pkg::IDX_LOCAL_FREQ, 16'h0009);
    rd_chk(css_pkg::IDX_PID_TARGET, 16'h0001);
    rd_chk(css_pkg::IDX_REMOTE_FREQ, 16'h0009);
    chk(16'(cmd_sel.pid_only), 16'h0001);
    bus(1'b1, css_pkg::IDX_LOCAL_FREQ, 16'h0000);
    rd_chk(css_pkg::IDX_LOCAL_FREQ, 16'h0009);
    bus(1'b1, css_pkg::IDX_PID_TARGET, 16'h0000);
    bus(1'b1, css_pkg::IDX_LOCAL_FREQ, 16'h0004);
    rd_chk(css_pkg::IDX_LOCAL_FREQ, 16'h0004);
    bus(1'b1, css_pkg::IDX_LR_POLICY, 16'h0001);
    setp(7'h20);
    wt(8);
    chk(16'(sw_cnt), 16'h0001);
    chk(16'(cmd_sel.local_mode), 16'h0001);
    chk(16'(cmd_sel.freq_src), 16'h0004);
    chk(16'(cmd_sel.pulse_no_dir), 16'h0001);
    chk(16'(cmd_sel.run_src), 16'h0002);
    chk(16'(cmd_sel.run_enable), 16'h0001);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    wt(1);
    chk(16'(cmd_sel.local_mode), 16'h0000);
    rd_chk(css_pkg::IDX_LR_POLICY, 16'h0004);
    rd_chk(css_pkg::IDX_LOCAL_FREQ, 16'h0000);
    print_verdict();
  end
endmodule

`default_nettype wire
